/* File: hdl/push_pull_gate_drive_pwm.sv */
`timescale 1ns/1ps
// Purpose: gate-drive timing for a push-pull lamp inverter with dimming
// Assumes: status inputs come from outside and are synchronised here
// Notes: outputs registered; drive state changes only on period boundaries

// Contract
// - low-side drives are 50% squares at half the pwm rate.
// - the two low-side drives are always complementary.
// - high-side pwm runs at twice the low-side frequency.
// - at most one high-side pulse per low-side on interval.
// - high-side and phase one both on means phase two off.
// - phase swap and new high-side pulse start together.
// - full duty holds high-side on continuously, unregulated.
// - high-side pulse width is the power control variable.
// - dimming gates the whole drive on and off above flicker rate.
// - after start-up, dimming on-fraction follows brightness input.
// - duty ramps step by step until regulation, the duty limit, full duty or fault.
module push_pull_gate_drive_pwm (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_run,
   input wire logic i_startup_done,
   input wire logic [gate_drive_pkg::BRIGHTNESS_LEVEL_INPUT_W-1:0] i_brightness_level_input,
   input wire logic [gate_drive_pkg::CNT_W-1:0] i_duty_limit,
   input wire gate_drive_pkg::loop_status_t i_status,
   // gate drives
   output logic o_high_side_pwm_drive,
   output logic o_low_side_drive_phase_one,
   output logic o_low_side_drive_phase_two,
   // status
   output logic o_drive_active,
   output logic [gate_drive_pkg::CNT_W-1:0] o_duty
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic [2:0] stat_s1_r;
   logic [2:0] stat_s2_r;
   logic run_s1_r;
   logic run_s2_r;
   logic start_s1_r;
   logic start_s2_r;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         stat_s1_r <= 3'h0;
         stat_s2_r <= 3'h0;
         run_s1_r <= 1'b0;
         run_s2_r <= 1'b0;
         start_s1_r <= 1'b0;
         start_s2_r <= 1'b0;
      end
      else
      begin
         stat_s1_r <= i_status;
         stat_s2_r <= stat_s1_r;
         run_s1_r <= i_run;
         run_s2_r <= run_s1_r;
         start_s1_r <= i_startup_done;
         start_s2_r <= start_s1_r;
      end
   end

   gate_drive_pkg::loop_status_t stat;
   assign stat = stat_s2_r;

   ////////////////////////////////////////////////////////////////////////
   // switching period counter

   logic [gate_drive_pkg::CNT_W-1:0] sw_cnt_r;
   logic period_end;
   assign period_end = (sw_cnt_r == gate_drive_pkg::SW_LAST);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !o_drive_active)
         sw_cnt_r <= '0;
      else if (period_end)
         sw_cnt_r <= '0;
      else
         sw_cnt_r <= sw_cnt_r + 9'h001;
   end

   ////////////////////////////////////////////////////////////////////////
   // dimming cycle: brightness sets the on-fraction

   logic [gate_drive_pkg::DIM_W-1:0] dim_cnt_r;
   logic [gate_drive_pkg::DIM_W-1:0] dim_on_periods;
   logic dim_on;
   // full brightness until start-up finishes, then the level input
   assign dim_on_periods = start_s2_r
      ? gate_drive_pkg::DIM_W'({1'b0, i_brightness_level_input} * 2)
      : gate_drive_pkg::DIM_W'(gate_drive_pkg::DIM_PERIODS);
   assign dim_on = run_s2_r && (dim_cnt_r < dim_on_periods);

   logic [gate_drive_pkg::CNT_W-1:0] tick_cnt_r;
   logic dim_tick;
   assign dim_tick = (tick_cnt_r == gate_drive_pkg::SW_LAST);

   // free-running period clock so dimming still advances during drive-off
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || dim_tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 9'h001;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         dim_cnt_r <= '0;
      else if (dim_tick)
         dim_cnt_r <= (dim_cnt_r == gate_drive_pkg::DIM_LAST) ? '0 : dim_cnt_r + 9'h001;
   end

   // drive gating changes only on a period boundary so no pulse is clipped
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_drive_active <= 1'b0;
      else if (!o_drive_active || period_end)
         o_drive_active <= dim_on;
   end

   ////////////////////////////////////////////////////////////////////////
   // duty regulation ramp

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !run_s2_r || stat.fault)
         o_duty <= gate_drive_pkg::DUTY_RESET;
      else if (stat.full_duty)
         o_duty <= gate_drive_pkg::DUTY_FULL;
      else if (period_end && !stat.in_regulation && o_duty < i_duty_limit
               && o_duty < gate_drive_pkg::DUTY_FULL)
         o_duty <= o_duty + gate_drive_pkg::RAMP_STEP;
   end

   ////////////////////////////////////////////////////////////////////////
   // phase toggle and high-side pwm

   // phase restarts at phase one whenever drive resumes
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !o_drive_active)
         o_low_side_drive_phase_one <= 1'b1;
      else if (period_end)
         o_low_side_drive_phase_one <= !o_low_side_drive_phase_one;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !o_drive_active)
         o_low_side_drive_phase_two <= 1'b0;
      else if (period_end)
         o_low_side_drive_phase_two <= o_low_side_drive_phase_one;
   end

   // gate for the next cycle's pulse: dimming decides only at a boundary
   logic dim_on_next;
   assign dim_on_next = (o_drive_active && !period_end)
      || ((!o_drive_active || period_end) && dim_on);

   // compare uses the counter one cycle ahead so pulse edge aligns with swap
   logic [gate_drive_pkg::CNT_W-1:0] cmp_cnt;
   assign cmp_cnt = (!o_drive_active || period_end) ? '0 : sw_cnt_r + 9'h001;

   pwm_compare #(
      .W(gate_drive_pkg::CNT_W)
   ) u_hs_cmp (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_count(cmp_cnt),
      .i_threshold(o_duty),
      .i_enable(dim_on_next),
      .o_level(o_high_side_pwm_drive)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_swap;
      period_end && o_drive_active;
   endsequence

   a_phase_complement : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_low_side_drive_phase_one != o_low_side_drive_phase_two)
      else $error("low-side drives not complementary");
   a_phase_toggle : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_swap ##1 o_drive_active |-> $changed(o_low_side_drive_phase_one))
      else $error("phase did not toggle at period end");
   a_pulse_start : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_swap ##1 (o_drive_active && $past(o_duty) != '0) |-> o_high_side_pwm_drive)
      else $error("high side pulse not started at swap");
   a_phase_hold : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_drive_active && !$past(period_end) && $past(o_drive_active)
      |-> $stable(o_low_side_drive_phase_one))
      else $error("phase changed mid period");
   a_offstate_quiet : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !o_drive_active ##1 !o_drive_active |-> !o_high_side_pwm_drive
      && o_low_side_drive_phase_one)
      else $error("drive not held off");
   a_full_duty : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_drive_active && $past(o_drive_active) && o_duty == gate_drive_pkg::DUTY_FULL
      && $past(o_duty) == gate_drive_pkg::DUTY_FULL && $past(dim_on_next)
      |-> o_high_side_pwm_drive)
      else $error("full duty not continuous");
   a_ramp_step : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_duty != '0 && !$past(stat.full_duty) && $past(run_s2_r) && !$past(stat.fault)
      |-> o_duty - $past(o_duty) <= gate_drive_pkg::RAMP_STEP)
      else $error("duty jumped by more than one step");
   a_fault_zero : assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stat.fault |=> o_duty == '0)
      else $error("duty not cleared on fault");

endmodule : push_pull_gate_drive_pwm

/* File: hdl/pwm_compare.sv */
`timescale 1ns/1ps
// Purpose: compare a free counter with a threshold to give a registered level
// Assumes: same clock as caller
// Notes: threshold equal to the period or above gives a constant high
module pwm_compare #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // compare inputs
   input wire logic [W-1:0] i_count,
   input wire logic [W-1:0] i_threshold,
   input wire logic i_enable,
   // level out
   output logic o_level
);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_level <= 1'b0;
      else
         o_level <= i_enable && (i_count < i_threshold);
   end

endmodule : pwm_compare

/* File: include/gate_drive_pkg.sv */
// Purpose: shared constants and carrier types for the push-pull gate drive
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: widths fixed; all timing counts derived here
package gate_drive_pkg;

   localparam int CLK_HZ = 20000000;
   // switching half-period (one high-side pwm period), 50 kHz nominal
   localparam int SW_FREQ_HZ = 50000;
   localparam int SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] SW_LAST = CNT_W'(SW_PERIOD_CYC - 1);
   localparam logic [CNT_W-1:0] DUTY_FULL = CNT_W'(SW_PERIOD_CYC);
   localparam logic [CNT_W-1:0] DUTY_RESET = 9'h000;
   // dimming cycle, 100 Hz nominal, counted in switching periods
   localparam int DIM_FREQ_HZ = 100;
   localparam int DIM_PERIODS = SW_FREQ_HZ / DIM_FREQ_HZ;
   localparam int DIM_W = 9;
   localparam logic [DIM_W-1:0] DIM_LAST = DIM_W'(DIM_PERIODS - 1);
   localparam int BRIGHTNESS_LEVEL_INPUT_W = 8;
   // ramp step applied once per switching period
   localparam logic [CNT_W-1:0] RAMP_STEP = 9'h001;

   typedef struct packed
   {
      logic high_side_pwm_drive;
      logic low_side_drive_phase_one;
      logic low_side_drive_phase_two;
   } gate_drive_t;

   typedef struct packed
   {
      logic in_regulation;
      logic fault;
      logic full_duty;
   } loop_status_t;

endpackage : gate_drive_pkg

/* File: tb/gate_drive_fets.sv */
// Purpose: far-side power stage seen by the gate drives
// Assumes: ideal switches, no parasitics
// Notes: flags both low sides on, which would short the primary
`timescale 1ns/1ps
module gate_drive_fets (
   // gate drives
   input wire logic i_high_side_switch,
   input wire logic i_low_side_switch_one,
   input wire logic i_low_side_switch_two,
   // winding state
   output logic [1:0] o_primary_dir,
   output logic o_shoot_through
);
   // winding that carries current while the high side conducts
   assign o_primary_dir = {2{i_high_side_switch}} &
      {i_low_side_switch_two, i_low_side_switch_one};
   assign o_shoot_through = i_low_side_switch_one & i_low_side_switch_two;
endmodule : gate_drive_fets

/* File: tb/push_pull_gate_drive_pwm_bench.sv */
// Purpose: self-checking bench for the gate drive timing
// Assumes: full brightness except in the dimming test, where the level drops to zero
// Notes: a dimming cycle is too long to run here
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module push_pull_gate_drive_pwm_bench;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_run = 1'b0;
   logic [8:0] i_duty_limit = 9'h000;
   logic start_done = 1'b0;
   logic [7:0] brightness_level_input = 8'hFF;
   gate_drive_pkg::loop_status_t i_status = '0;
   logic hs, ph1, ph2, active, shoot;
   logic [gate_drive_pkg::CNT_W-1:0] duty;
   logic [1:0] primary;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   push_pull_gate_drive_pwm i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_run(i_run),
      .i_startup_done(start_done), .i_brightness_level_input(brightness_level_input),
      .i_duty_limit(i_duty_limit),
      .i_status(i_status), .o_high_side_pwm_drive(hs), .o_low_side_drive_phase_one(ph1),
      .o_low_side_drive_phase_two(ph2), .o_drive_active(active), .o_duty(duty));
   gate_drive_fets i_fets (.i_high_side_switch(hs), .i_low_side_switch_one(ph1),
      .i_low_side_switch_two(ph2), .o_primary_dir(primary), .o_shoot_through(shoot));
   initial
   begin
      forever #25 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic wait_duty(input logic [8:0] v);
      int n;
      n = 0;
      while (duty !== v && n < 5000)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK(duty, v)
   endtask : wait_duty
   // one full half-period, starting at the swap
   task automatic check_half(input int exp_high);
      int high, rises, falls, same, n;
      logic ph_start, prev;
      high = 0;
      rises = 0;
      falls = 0;
      same = 0;
      n = 0;
      ph_start = ph1;
      while (ph1 === ph_start && n < 1000)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK(hs, exp_high != 0)
      `CHK(primary, (exp_high == 0) ? 2'b00 : (ph1 ? 2'b01 : 2'b10))
      ph_start = ph1;
      prev = hs;
      for (n = 0; n < 400; n++)
      begin
         `CHK(ph2, ~ph1)
         `CHK(shoot, 1'b0)
         high += (hs === 1'b1);
         same += (ph1 === ph_start);
         rises += (hs === 1'b1 && prev === 1'b0);
         falls += (hs === 1'b0 && prev === 1'b1);
         prev = hs;
         @(negedge i_clk);
      end
      `CHK(same, 400)
      `CHK(ph1, ~ph_start)
      `CHK(high, exp_high)
      `CHK(rises, 0)
      `CHK(falls, (exp_high > 0 && exp_high < 400) ? 1 : 0)
   endtask : check_half
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ramp();
      @(posedge i_clk);
      i_duty_limit <= 9'h003;
      i_run <= 1'b1;
      wait_duty(9'h003);
      repeat (800) @(negedge i_clk);
      `CHK(duty, 9'h003)
      `CHK(active, 1'b1)
      check_half(3);
      check_half(3);
      $display("test ramp done");
   endtask : t_ramp
   // level zero after start-up gates drive off at a boundary; full level resumes it
   task automatic t_dim();
      int n;
      @(posedge i_clk);
      start_done <= 1'b1;
      brightness_level_input <= 8'h00;
      n = 0;
      while (active !== 1'b0 && n < 1000)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK(active, 1'b0)
      repeat (800)
      begin
         @(negedge i_clk);
         `CHK({hs, ph1, ph2}, 3'b010)
      end
      @(posedge i_clk);
      brightness_level_input <= 8'hFF;
      n = 0;
      while (active !== 1'b1 && n < 1000)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK({active, hs, ph1, ph2}, 4'hE)
      check_half(3);
      $display("test dimming done");
   endtask : t_dim
   task automatic t_full();
      @(posedge i_clk);
      i_status.full_duty <= 1'b1;
      wait_duty(gate_drive_pkg::DUTY_FULL);
      check_half(400);
      $display("test full duty done");
   endtask : t_full
   task automatic t_fault_stop();
      int n;
      @(posedge i_clk);
      i_status <= 3'b010;
      wait_duty(9'h000);
      check_half(0);
      @(posedge i_clk);
      i_status <= '0;
      i_run <= 1'b0;
      n = 0;
      while (active !== 1'b0 && n < 1000)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK(active, 1'b0)
      repeat (900)
      begin
         @(negedge i_clk);
         `CHK(hs, 1'b0)
      end
      `CHK({ph1, ph2}, 2'b10)
      $display("test fault and stop done");
   endtask : t_fault_stop
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(negedge i_clk);
      `CHK({hs, ph1, ph2, active, duty}, {4'h4, 9'h000})
      t_ramp();
      t_dim();
      t_full();
      t_fault_stop();
      give_verdict();
   end
endmodule : push_pull_gate_drive_pwm_bench
